// [dlc_pkg.sv]
/*
 * Package for the DAC load / lookup configuration block.
 * Holds command codes, field positions, widths and reset values.
 * Assumes a serial front end that delivers whole command/data words.
 */
package dlc_pkg;
    // Command bytes for the configuration register
    localparam logic [7:0]  CMD_CFG_WRITE      = 8'h3a;
    localparam logic [7:0]  CMD_CFG_READ       = 8'hba;
    // Register width and writable mask (top four bits are don't care)
    localparam int          CFG_W              = 16;
    localparam logic [15:0] CFG_WR_MASK        = 16'h0fff;
    localparam logic [15:0] CFG_RESET          = 16'h0000;
    // Field positions
    localparam int          CH2_LOAD_SEL_POS   = 11;
    localparam int          CH2_TEMP_LSB       = 9;
    localparam int          CH2_KSRC_LSB       = 6;
    localparam int          CH1_LOAD_SEL_POS   = 5;
    localparam int          CH1_TEMP_LSB       = 3;
    localparam int          CH1_KSRC_LSB       = 0;
    // Field widths and special encodings
    localparam int          CODE_W             = 12;
    localparam int          LUT_W              = 12;
    localparam logic [2:0]  KSRC_NONE          = 3'h0;
    localparam logic [1:0]  TEMP_OFF_PLUS      = 2'h0;
    localparam logic [1:0]  TEMP_OFF_MINUS     = 2'h1;
    localparam logic [1:0]  TEMP_EXT           = 2'h2;
    localparam logic [1:0]  TEMP_INT           = 2'h3;
    localparam logic [11:0] CODE_RESET         = 12'h000;
endpackage

// [dlc_top.sv]
/*
 * DAC load / lookup configuration block for two gate-bias channels.
 * Holds the software configuration register, decodes its write and read
 * commands, computes each channel's DAC code and routes it to the input
 * register only or to input and output registers, pulsing busy.
 * Assumes a serial front end on clk_sys that hands over one decoded
 * command byte with its 16-bit data as a one-cycle strobe, and lookup
 * values presented by the lookup memory logic as signed fractions.
 */
// Contract
// R1 - Ch2 load-select 1 updates input and output
// R2 - Busy pulses after output update with load-select
// R3 - Ch2 load-select 0 updates input only
// R4 - Ch2 transfer bit copies input to output
// R5 - Ch1 load-select 1 updates input and output
// R6 - Ch1 load-select 0 updates input only
// R7 - Ch1 transfer bit copies input to output
// R8 - Bits ten-nine are ch2 temperature control
// R9 - Bits eight-six are ch2 K source
// R10 - Bits four-three are ch1 temperature control
// R11 - Bits two-zero are ch1 K source
// R12 - Write with 3Ah, read with BAh
// R13 - Code equals setpoint times one plus K*temp
// R14 - Temperature change triggers only for settings 10/11
// R15 - K source zero uses temperature term alone
// R16 - Busy one cycle; top four bits ignored
`timescale 1ns/100ps
`default_nettype none
module dlc_top
    import dlc_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    // Command port from the serial front end
    input  wire logic                        cmd_valid,
    input  wire logic [7:0]                  cmd_byte,
    input  wire logic [dlc_pkg::CFG_W-1:0]   cmd_wdata,
    output logic      [dlc_pkg::CFG_W-1:0]   cmd_rdata,
    output logic                             cmd_rvalid,
    // Setpoint writes, per channel (index 0 = ch1, 1 = ch2)
    input  wire logic [1:0]                  setpoint_wr,
    input  wire logic [dlc_pkg::CODE_W-1:0]  setpoint_ch1,
    input  wire logic [dlc_pkg::CODE_W-1:0]  setpoint_ch2,
    // Lookup values, signed fractions with 11 fraction bits
    input  wire logic [dlc_pkg::LUT_W-1:0]   k_lut_ch1,
    input  wire logic [dlc_pkg::LUT_W-1:0]   k_lut_ch2,
    input  wire logic [dlc_pkg::LUT_W-1:0]   temp_lut_ch1,
    input  wire logic [dlc_pkg::LUT_W-1:0]   temp_lut_ch2,
    // Temperature change events
    input  wire logic [1:0]                  ext_temp_new,
    input  wire logic                        int_temp_new,
    // Software load DAC transfer bits, one-cycle strobes
    input  wire logic                        ch1_transfer_bit,
    input  wire logic                        ch2_transfer_bit,
    // Configuration fields to the lookup logic
    output logic      [1:0]                  ch1_temp_ctrl,
    output logic      [2:0]                  ch1_ksource,
    output logic      [1:0]                  ch2_temp_ctrl,
    output logic      [2:0]                  ch2_ksource,
    // DAC registers and busy
    output logic      [dlc_pkg::CODE_W-1:0]  dac_in_ch1,
    output logic      [dlc_pkg::CODE_W-1:0]  dac_in_ch2,
    output logic      [dlc_pkg::CODE_W-1:0]  dac_out_ch1,
    output logic      [dlc_pkg::CODE_W-1:0]  dac_out_ch2,
    output logic                             busy
);
    import dlc_pkg::*;

    // Reset release through two flops
    logic rst_sync1_ff;
    logic rst_n_ff;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_ff <= 1'b0;
            rst_n_ff     <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_n_ff     <= rst_sync1_ff;
        end
    end

    // Configuration register and command answer
    logic [CFG_W-1:0] cfg_ff;
    logic [CFG_W-1:0] nxt_cfg;
    logic [CFG_W-1:0] rdata_ff;
    logic [CFG_W-1:0] nxt_rdata;
    logic             rvalid_ff;
    logic             nxt_rvalid;

    // Decode write and read commands; upper nibble is dropped
    always_comb begin
        nxt_cfg    = cfg_ff;
        nxt_rdata  = rdata_ff;
        nxt_rvalid = 1'b0;
        if (cmd_valid && cmd_byte == CMD_CFG_WRITE) begin // see R12
            nxt_cfg = cmd_wdata & CFG_WR_MASK; // see R16
        end
        if (cmd_valid && cmd_byte == CMD_CFG_READ) begin // see R12
            nxt_rdata  = cfg_ff;
            nxt_rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cfg_ff    <= CFG_RESET;
            rdata_ff  <= CFG_RESET;
            rvalid_ff <= 1'b0;
        end else begin
            cfg_ff    <= nxt_cfg;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign cmd_rdata  = rdata_ff;
    assign cmd_rvalid = rvalid_ff;

    // Field extraction
    assign ch2_temp_ctrl = cfg_ff[CH2_TEMP_LSB +: 2]; // see R8
    assign ch2_ksource   = cfg_ff[CH2_KSRC_LSB +: 3]; // see R9
    assign ch1_temp_ctrl = cfg_ff[CH1_TEMP_LSB +: 2]; // see R10
    assign ch1_ksource   = cfg_ff[CH1_KSRC_LSB +: 3]; // see R11

    // Per-channel views as arrays for the generate loop
    logic [1:0]        load_sel;
    logic [1:0]        xfer;
    logic [1:0][1:0]   tctl;
    logic [1:0][2:0]   ksrc;
    logic [1:0][CODE_W-1:0] sp;
    logic [1:0][LUT_W-1:0]  k_lookup_table;
    logic [1:0][LUT_W-1:0]  tlut;
    logic [1:0][CODE_W-1:0] din;
    logic [1:0][CODE_W-1:0] dout;
    logic [1:0]        out_upd;

    assign load_sel = {cfg_ff[CH2_LOAD_SEL_POS], cfg_ff[CH1_LOAD_SEL_POS]};
    assign xfer     = {ch2_transfer_bit, ch1_transfer_bit};
    assign tctl     = {ch2_temp_ctrl, ch1_temp_ctrl};
    assign ksrc     = {ch2_ksource, ch1_ksource};
    assign sp       = {setpoint_ch2, setpoint_ch1};
    assign k_lookup_table     = {k_lut_ch2, k_lut_ch1};
    assign tlut     = {temp_lut_ch2, temp_lut_ch1};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic [CODE_W-1:0] sp_ff;
            logic [CODE_W-1:0] nxt_sp;
            logic [CODE_W-1:0] din_ff;
            logic [CODE_W-1:0] nxt_din;
            logic [CODE_W-1:0] dout_ff;
            logic [CODE_W-1:0] nxt_dout;
            logic              calc_go;
            logic              temp_trig;
            logic              upd;
            logic signed [23:0] term;
            logic signed [13:0] factor;
            logic signed [26:0] prod;
            logic [CODE_W-1:0] code;

            // Temperature events only count for the sensing modes
            always_comb begin
                case (tctl[ch])
                    TEMP_EXT: temp_trig = ext_temp_new[ch]; // see R14
                    TEMP_INT: temp_trig = int_temp_new;     // see R14
                    default:  temp_trig = 1'b0;
                endcase
            end
            assign calc_go = setpoint_wr[ch] | temp_trig; // see R13

            // Code = setpoint * (1 +/- K*T); one missing term counts as one
            always_comb begin
                logic signed [12:0] kv;
                logic signed [12:0] tv;
                kv = (ksrc[ch] == KSRC_NONE) ? 13'sh0800 : {k_lookup_table[ch][LUT_W-1], k_lookup_table[ch]}; // see R15
                tv = (tctl[ch][1]) ? {tlut[ch][LUT_W-1], tlut[ch]} : 13'sh0800;
                term = 24'(kv) * 24'(tv); // Q2.22, 1.0 = 2^22
                // Neither lookup in use: setpoint passes, not doubled
                if (ksrc[ch] == KSRC_NONE && !tctl[ch][1])
                    term = 24'sh000000;
                // Factor spans 0..2.0, so it needs two bits more than a lookup value
                if (tctl[ch] == TEMP_OFF_MINUS)
                    factor = 14'sh0800 - 14'(term >>> 11);
                else
                    factor = 14'sh0800 + 14'(term >>> 11); // see R13
                prod = 27'($signed({1'b0, nxt_sp})) * 27'(factor);
                // Saturate: a code cannot go negative or past full scale
                if (prod < 0)
                    code = CODE_RESET;
                else if (prod[26:23] != 4'h0)
                    code = 12'hfff;
                else
                    code = prod[22:11];
            end

            // Route new codes; long multiply path is one cycle at 10 MHz
            always_comb begin
                nxt_sp   = setpoint_wr[ch] ? sp[ch] : sp_ff;
                nxt_din  = din_ff;
                nxt_dout = dout_ff;
                upd      = 1'b0;
                if (calc_go) begin
                    nxt_din = code; // see R3 see R6
                    if (load_sel[ch]) begin
                        nxt_dout = code; // see R1 see R5
                        upd      = 1'b1;
                    end
                end else if (xfer[ch] && !load_sel[ch]) begin
                    nxt_dout = din_ff; // see R4 see R7
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    sp_ff   <= CODE_RESET;
                    din_ff  <= CODE_RESET;
                    dout_ff <= CODE_RESET;
                end else begin
                    sp_ff   <= nxt_sp;
                    din_ff  <= nxt_din;
                    dout_ff <= nxt_dout;
                end
            end

            assign din[ch]     = din_ff;
            assign dout[ch]    = dout_ff;
            assign out_upd[ch] = upd;
        end
    endgenerate

    // Busy: one cycle after any computed output update
    logic busy_ff;
    logic nxt_busy;
    always_comb begin
        nxt_busy = |out_upd; // see R2 see R16
    end
    always_ff @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
        end
    end

    assign busy        = busy_ff;
    assign dac_in_ch1  = din[0];
    assign dac_in_ch2  = din[1];
    assign dac_out_ch1 = dout[0];
    assign dac_out_ch2 = dout[1];
endmodule
`default_nettype wire

// [dlc_props.sv]
/*
 * Checker for the DAC load / lookup configuration block.
 * Sees only top-level ports; bound to dlc_top at the foot of this file.
 */
`timescale 1ns/100ps
`default_nettype none
module dlc_props
    import dlc_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // Command port
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_byte,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_rvalid,
    // Compute and transfer triggers
    input wire logic [1:0]  setpoint_wr,
    input wire logic [1:0]  ext_temp_new,
    input wire logic        int_temp_new,
    input wire logic        ch1_transfer_bit,
    // Fields, DAC registers, busy
    input wire logic [1:0]  ch1_temp_ctrl,
    input wire logic [2:0]  ch1_ksource,
    input wire logic [1:0]  ch2_temp_ctrl,
    input wire logic [2:0]  ch2_ksource,
    input wire logic [11:0] dac_in_ch1,
    input wire logic [11:0] dac_out_ch1,
    input wire logic [11:0] dac_in_ch2,
    input wire logic [11:0] dac_out_ch2,
    input wire logic        busy
);
    logic [1:0] ls_ff;
    logic [1:0] nxt_ls;
    // Load-select mirror, since the register itself is not a port
    always_comb begin
        nxt_ls = ls_ff;
        if (cmd_valid && cmd_byte == CMD_CFG_WRITE) nxt_ls = {cmd_wdata[CH2_LOAD_SEL_POS], cmd_wdata[CH1_LOAD_SEL_POS]};
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) ls_ff <= 2'h0;
        else ls_ff <= nxt_ls;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_wr; cmd_valid && cmd_byte == CMD_CFG_WRITE; endsequence
    sequence s_rd; cmd_valid && cmd_byte == CMD_CFG_READ; endsequence
    // Field outputs and read answers
    AST_WR_CH2: assert property (s_wr |=> {ch2_temp_ctrl, ch2_ksource} == $past(cmd_wdata[10:6]))
        else $error("ch2 fields differ from write");
    AST_WR_CH1: assert property (s_wr |=> {ch1_temp_ctrl, ch1_ksource} == $past(cmd_wdata[4:0]))
        else $error("ch1 fields differ from write");
    AST_RD_ANS: assert property (s_rd |=> cmd_rvalid && cmd_rdata[15:12] == 4'h0)
        else $error("read answer missing or top bits set");
    AST_RD_CAUSE: assert property (cmd_rvalid |-> $past(cmd_valid) && $past(cmd_byte) == CMD_CFG_READ)
        else $error("read answer without read command");
    AST_RD_DATA: assert property (s_wr ##1 s_rd |=> cmd_rdata[11:0] == $past(cmd_wdata[11:0], 2))
        else $error("read back differs from write");
    // DAC register routing and busy
    AST_BUSY_CAUSE: assert property (busy |-> $past(|setpoint_wr || |ext_temp_new || int_temp_new))
        else $error("busy without a compute");
    AST_CH1_HOLD: assert property (setpoint_wr[0] && !ls_ff[0] && !ch1_transfer_bit |=> $stable(dac_out_ch1))
        else $error("ch1 output moved with load-select clear");
    AST_CH2_BOTH: assert property (setpoint_wr[1] && ls_ff[1] |=> dac_out_ch2 == dac_in_ch2 && busy)
        else $error("ch2 output or busy not updated");
    AST_CH1_XFER: assert property (ch1_transfer_bit && !ls_ff[0] && !setpoint_wr[0] && !ext_temp_new[0]
        && !int_temp_new |=> dac_out_ch1 == $past(dac_in_ch1))
        else $error("ch1 transfer did not copy input");
endmodule
bind dlc_top dlc_props u_props (.*);
`default_nettype wire

// [tb_dlc_load_lut_config.sv]
/*
 * Self-checking bench for dlc_top: random configs, setpoints and events.
 * Assumes dlc_pkg and dlc_props compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_dlc_load_lut_config;
    import dlc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        arst_n, cmd_valid, cmd_rvalid, int_temp_new, ch1_transfer_bit, ch2_transfer_bit, busy;
    logic [7:0]  cmd_byte;
    logic [15:0] cmd_wdata, cmd_rdata, cfg_m;
    logic [1:0]  setpoint_wr, ext_temp_new, ch1_temp_ctrl, ch2_temp_ctrl;
    logic [2:0]  ch1_ksource, ch2_ksource;
    logic [11:0] setpoint_ch1, setpoint_ch2, k_lut_ch1, k_lut_ch2, temp_lut_ch1, temp_lut_ch2;
    logic [11:0] dac_in_ch1, dac_in_ch2, dac_out_ch1, dac_out_ch2;
    int          n_mismatch, num_checks;
    int unsigned seed = 10;
    dlc_top dut (.*);
    always #50 clk_sys = ~clk_sys;
    // Xorshift keeps runs repeatable
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected code; with neither lookup in use the setpoint passes unchanged
    function automatic int code(int sp, int k, int t, int ks, int tc);
        int kv, tv, tm, f;
        kv = k > 2047 ? k - 4096 : k;
        tv = t > 2047 ? t - 4096 : t;
        if (ks == 0) tm = tc > 1 ? tv : 0;
        else tm = tc > 1 ? (kv * tv) >>> 11 : kv;
        f = (sp * (tc == 1 ? 2048 - tm : 2048 + tm)) >>> 11;
        return f > 4095 ? 4095 : f;
    endfunction
    function automatic logic [11:0] din(input int ch);
        return ch ? dac_in_ch2 : dac_in_ch1;
    endfunction
    function automatic logic [11:0] dout(input int ch);
        return ch ? dac_out_ch2 : dac_out_ch1;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Command strobe set at a falling edge; hold keeps it up for a chained command
    task automatic cmd(input logic [7:0] b, input logic [15:0] d, input bit hold);
        cmd_valid = 1'b1;
        cmd_byte = b;
        cmd_wdata = d;
        @(negedge clk_sys);
        if (!hold) cmd_valid = 1'b0;
    endtask
    task automatic setv(input int sp, input int k, input int t);
        {setpoint_ch1, setpoint_ch2} = {2{sp[11:0]}};
        {k_lut_ch1, k_lut_ch2} = {2{k[11:0]}};
        {temp_lut_ch1, temp_lut_ch2} = {2{t[11:0]}};
    endtask
    task automatic step(input int i);
        int ch, tc, ks, ls, sp, k, t, e;
        logic [15:0] w;
        logic [11:0] old;
        ch = i % 2;
        tc = (i / 2) % 4;
        ls = (i / 8) % 2;
        ks = (i / 16) ? int'(rnd() % 8) : 0;
        w = 16'(rnd());
        w[ch*6 +: 6] = 6'(ls * 32 + tc * 8 + ks);
        cmd(CMD_CFG_WRITE, w, 1'b1);
        chk(ch ? {ch2_temp_ctrl, ch2_ksource} : {ch1_temp_ctrl, ch1_ksource}, w[ch*6 +: 5]);
        cmd(CMD_CFG_READ, 16'h0000, 1'b0);
        chk(cmd_rvalid, 1'b1);
        chk(cmd_rdata, w & CFG_WR_MASK);
        cfg_m = w & CFG_WR_MASK;
        sp = rnd() % 4096;
        k = rnd() % 4096;
        t = rnd() % 4096;
        setv(sp, k, t);
        e = code(sp, k, t, ks, tc);
        old = dout(ch);
        setpoint_wr = 2'(1 << ch);
        @(negedge clk_sys);
        setpoint_wr = 2'h0;
        chk(dout(ch), ls ? 16'(e) : {4'h0, old});
        chk(busy, 16'(ls));
        chk(din(ch), 16'(e));
        chk(cmd_rvalid, 16'h0000);
        // Transfer strobe: copies with load-select clear, ignored with it set
        ch1_transfer_bit = (ch == 0);
        ch2_transfer_bit = (ch == 1);
        @(negedge clk_sys);
        {ch1_transfer_bit, ch2_transfer_bit} = 2'h0;
        chk(dout(ch), 16'(e));
        chk(busy, 16'h0000);
        // External then internal event, each with a fresh temperature value
        t = rnd() % 4096;
        setv(sp, k, t);
        ext_temp_new = 2'(1 << ch);
        @(negedge clk_sys);
        ext_temp_new = 2'h0;
        if (tc == 2) e = code(sp, k, t, ks, tc);
        t = rnd() % 4096;
        setv(sp, k, t);
        int_temp_new = 1'b1;
        @(negedge clk_sys);
        int_temp_new = 1'b0;
        if (tc == 3) e = code(sp, k, t, ks, tc);
        chk(din(ch), 16'(e));
        $display("test %0d done", i);
    endtask
    // Main sequence; reset released at a falling edge
    initial begin
        {arst_n, cmd_valid, int_temp_new, ch1_transfer_bit, ch2_transfer_bit} = 5'h00;
        {cmd_byte, cmd_wdata, setpoint_wr, ext_temp_new} = 28'h0000000;
        setv(0, 0, 0);
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        cmd(CMD_CFG_READ, 16'h0000, 1'b1);
        chk(cmd_rdata, CFG_RESET);
        chk(dac_in_ch1 | dac_in_ch2 | dac_out_ch1 | dac_out_ch2, 16'h0000);
        for (int i = 0; i < 32; i++) step(i);
        // An unknown code must leave the register alone
        cmd(8'h3b, 16'hffff, 1'b1);
        cmd(CMD_CFG_READ, 16'h0000, 1'b0);
        chk(cmd_rdata, cfg_m);
        $display("test unknown command done");
        results();
    end
    // Watchdog: the tests need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
